// ---- pkg/scomux_pkg.sv ----
// Purpose: Shared constants and types of the shared pin clock output mux
// Assumes: Registers reached by APB, byte address is four times the index
// Notes:   Mode codes are the pin-function field encodings
package scomux_pkg;
	localparam int          ADDR_W        = 18;
	localparam int          DIV_W         = 5;
	localparam logic [15:0] IDX_CSS       = 16'hf06f;
	localparam logic [15:0] IDX_PFM       = 16'hffc0;
	localparam logic [15:0] IDX_PORT      = 16'hffd0;
	localparam logic [17:0] ADDR_CSS      = {IDX_CSS, 2'h0};
	localparam logic [17:0] ADDR_PFM      = {IDX_PFM, 2'h0};
	localparam logic [17:0] ADDR_PORT     = {IDX_PORT, 2'h0};
	localparam int          PFM_LSB       = 0;
	localparam int          CSS_SRC_LSB   = 4;
	localparam int          PORT_DATA_BIT = 0;
	localparam int          PORT_DIR_BIT  = 1;
	localparam int          PORT_PIN_BIT  = 2;
	localparam logic [2:0]  PFM_RST       = 3'h0;
	localparam logic [2:0]  CSS_RST       = 3'h0;
	localparam logic [1:0]  PORT_RST      = 2'h0;
	localparam logic [2:0]  PFM_GP        = 3'h0;
	localparam logic [2:0]  PFM_EVT       = 3'h1;
	localparam logic [1:0]  PFM_TMR_HI    = 2'h1;
	localparam logic [2:0]  PFM_OSC1      = 3'h4;
	localparam logic [2:0]  PFM_OSC2      = 3'h5;
	localparam logic [2:0]  PFM_OSC4      = 3'h6;
	localparam logic [1:0]  SRC_DIV4      = 2'h0;
	localparam logic [1:0]  SRC_DIV8      = 2'h1;
	localparam logic [1:0]  SRC_DIV16     = 2'h2;

	typedef enum logic [6:0] {
		ROLE_GP   = 7'h01,
		ROLE_EVT  = 7'h02,
		ROLE_TMR  = 7'h04,
		ROLE_OSC1 = 7'h08,
		ROLE_OSC2 = 7'h10,
		ROLE_OSC4 = 7'h20,
		ROLE_OFF  = 7'h40
	} scomux_role_t;
endpackage

// ---- pkg/scomux_div_if.sv ----
// Purpose: Carries the divider taps from the divider to the selector
// Assumes: Tap k toggles at the clock rate divided by two to the k plus one
// Notes:   One producer, one consumer
`timescale 1ns/1ps
interface scomux_div_if #(parameter int W = 5);
	logic [W-1:0] tap;
	modport src (output tap);
	modport dst (input tap);
endinterface

// ---- design/scomux_div.sv ----
// Purpose: Free-running binary divider for the clock outputs
// Assumes: Runs on the oscillator clock, which is also the system clock
// Notes:   Never stopped, so a new selection needs no restart
`timescale 1ns/1ps
module scomux_div #(
	parameter int W = 5
) (
	input  wire logic  clk_in,
	input  wire logic  rstn_in,
	scomux_div_if.src  taps_out
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;

	always_comb begin
		next_cnt = cnt + {{(W-1){1'b0}}, 1'b1};
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	assign taps_out.tap = cnt;

	a_div_counts: assert property (@(posedge clk_in) disable iff (!rstn_in)
		$past(rstn_in) |-> cnt == $past(cnt) + {{(W-1){1'b0}}, 1'b1}) else $error("Divider did not advance");
endmodule

// ---- design/scomux_top.sv ----
// Purpose: Function selector and clock output mux for one shared pin
// Assumes: MCLK_IN is the oscillator clock and the system clock alike
// Notes:   Undivided output passes MCLK_IN through a mux, so it may glitch on mode change
`timescale 1ns/1ps
module scomux_top
#(
	parameter int DW = scomux_pkg::DIV_W
) (
	input  wire logic                      MCLK_IN,
	input  wire logic                      RSTN_IN,
	input  wire logic                      PSEL_IN,
	input  wire logic                      PENABLE_IN,
	input  wire logic                      PWRITE_IN,
	input  wire logic [scomux_pkg::ADDR_W-1:0] PADDR_IN,
	input  wire logic [31:0]               PWDATA_IN,
	output logic      [31:0]               PRDATA_OUT,
	output logic                           PREADY_OUT,
	output logic                           PSLVERR_OUT,
	input  wire logic                      PIN_IN,
	output logic                           PIN_OUT,
	output logic                           PIN_OE_OUT,
	input  wire logic                      WATCH_CLK_IN,
	input  wire logic                      TIMER_IO_OUT_IN,
	input  wire logic                      TIMER_IO_OE_IN,
	output logic                           TIMER_IO_IN_OUT,
	output logic                           EVENT_OUT
);
	import scomux_pkg::*;

	scomux_div_if #(.W(DW)) div_bus ();
	scomux_div #(.W(DW)) u_div (
		.clk_in   (MCLK_IN),
		.rstn_in  (RSTN_IN),
		.taps_out (div_bus.src)
	);

	logic [2:0]   pfm;
	logic [2:0]   css;
	logic [1:0]   port;
	logic [31:0]  rdata;
	logic         slverr;
	logic [2:0]   next_pfm;
	logic [2:0]   next_css;
	logic [1:0]   next_port;
	logic [31:0]  next_rdata;
	logic         next_slverr;
	logic         setup;
	logic         access_wr;
	logic         hit;

	logic         pin_s1;
	logic         pin_s2;
	logic         watch_s1;
	logic         watch_s2;
	scomux_role_t role;
	scomux_role_t next_role;
	logic         pin_q;
	logic         next_pin_q;
	logic         oe_q;
	logic         next_oe_q;

	assign setup     = PSEL_IN && !PENABLE_IN;
	assign access_wr = PSEL_IN && PENABLE_IN && PWRITE_IN;
	assign hit       = (PADDR_IN == ADDR_CSS) || (PADDR_IN == ADDR_PFM) || (PADDR_IN == ADDR_PORT);

	// Read data and error latched in setup, so the access phase never waits
	always_comb begin
		next_pfm    = pfm;
		next_css    = css;
		next_port   = port;
		next_rdata  = rdata;
		next_slverr = slverr;
		if (setup) begin
			next_slverr = !hit;
			next_rdata  = 32'h0;
			if (PADDR_IN == ADDR_PFM) begin
				next_rdata[PFM_LSB +: 3] = pfm;
			end else if (PADDR_IN == ADDR_CSS) begin
				next_rdata[CSS_SRC_LSB +: 3] = css;
			end else if (PADDR_IN == ADDR_PORT) begin
				next_rdata[PORT_DATA_BIT] = port[0];
				next_rdata[PORT_DIR_BIT]  = port[1];
				next_rdata[PORT_PIN_BIT]  = pin_s2;
			end
		end
		if (access_wr) begin
			if (PADDR_IN == ADDR_PFM) begin
				next_pfm = PWDATA_IN[PFM_LSB +: 3];
			end
			if (PADDR_IN == ADDR_CSS) begin
				next_css = PWDATA_IN[CSS_SRC_LSB +: 3];
			end
			if (PADDR_IN == ADDR_PORT) begin
				next_port = {PWDATA_IN[PORT_DIR_BIT], PWDATA_IN[PORT_DATA_BIT]};
			end
		end
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pfm    <= PFM_RST;
			css    <= CSS_RST;
			port   <= PORT_RST;
			rdata  <= 32'h0;
			slverr <= 1'b0;
		end else begin
			pfm    <= next_pfm;
			css    <= next_css;
			port   <= next_port;
			rdata  <= next_rdata;
			slverr <= next_slverr;
		end
	end

	assign PRDATA_OUT  = rdata;
	assign PREADY_OUT  = 1'b1;
	assign PSLVERR_OUT = PSEL_IN && PENABLE_IN && slverr;

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			pin_s1   <= 1'b0;
			pin_s2   <= 1'b0;
			watch_s1 <= 1'b0;
			watch_s2 <= 1'b0;
		end else begin
			pin_s1   <= PIN_IN;
			pin_s2   <= pin_s1;
			watch_s1 <= WATCH_CLK_IN;
			watch_s2 <= watch_s1;
		end
	end

	// Prohibited code 111 floats the pin rather than guessing a function
	always_comb begin
		next_role = ROLE_OFF;
		case (pfm)
			PFM_GP:   next_role = ROLE_GP;
			PFM_EVT:  next_role = ROLE_EVT;
			PFM_OSC1: next_role = ROLE_OSC1;
			PFM_OSC2: next_role = ROLE_OSC2;
			PFM_OSC4: next_role = ROLE_OSC4;
			default: begin
				if (pfm[2:1] == PFM_TMR_HI) begin
					next_role = ROLE_TMR;
				end else begin
					next_role = ROLE_OFF;
				end
			end
		endcase
	end

	always_comb begin
		next_pin_q = 1'b0;
		next_oe_q  = 1'b1;
		case (role)
			ROLE_GP: begin
				next_pin_q = TIMER_IO_OE_IN ? TIMER_IO_OUT_IN : port[0];
				next_oe_q  = TIMER_IO_OE_IN || port[1];
			end
			ROLE_EVT: next_oe_q = 1'b0;
			ROLE_TMR: begin
				if (css[0]) begin
					next_pin_q = watch_s2;
				end else begin
					case (css[2:1])
						SRC_DIV4:  next_pin_q = div_bus.tap[1];
						SRC_DIV8:  next_pin_q = div_bus.tap[2];
						SRC_DIV16: next_pin_q = div_bus.tap[3];
						default:   next_pin_q = div_bus.tap[4];
					endcase
				end
			end
			ROLE_OSC2: next_pin_q = div_bus.tap[0];
			ROLE_OSC4: next_pin_q = div_bus.tap[1];
			ROLE_OSC1: next_pin_q = 1'b0;
			default:   next_oe_q  = 1'b0;
		endcase
	end

	always_ff @(posedge MCLK_IN or negedge RSTN_IN) begin
		if (!RSTN_IN) begin
			role  <= ROLE_GP;
			pin_q <= 1'b0;
			oe_q  <= 1'b0;
		end else begin
			role  <= next_role;
			pin_q <= next_pin_q;
			oe_q  <= next_oe_q;
		end
	end

	// Undivided clock cannot come from a flop running on the same clock
	assign PIN_OUT         = (role == ROLE_OSC1) ? MCLK_IN : pin_q;
	assign PIN_OE_OUT      = oe_q;
	assign TIMER_IO_IN_OUT = (role == ROLE_GP) ? pin_s2 : 1'b0;
	assign EVENT_OUT       = (role == ROLE_EVT) ? pin_s2 : 1'b0;

	sequence s_pfm_write(logic [2:0] code);
		access_wr && (PADDR_IN == ADDR_PFM) && (PWDATA_IN[2:0] == code);
	endsequence

	sequence s_no_pfm_write;
		!(access_wr && (PADDR_IN == ADDR_PFM));
	endsequence

	a_osc1_role_follow: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_pfm_write(PFM_OSC1) ##1 s_no_pfm_write |=> role == ROLE_OSC1) else $error("Mode 100 not taken");
	a_tmr_role_follow: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		s_pfm_write(3'h3) ##1 s_no_pfm_write |=> role == ROLE_TMR) else $error("Mode 011 not timer out");
	a_osc2_tracks: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(role == ROLE_OSC2) && ($past(role) == ROLE_OSC2) |-> PIN_OE_OUT && (PIN_OUT == $past(div_bus.tap[0])))
		else $error("Divide by two output wrong");
	a_osc4_tracks: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(role == ROLE_OSC4) && ($past(role) == ROLE_OSC4) |-> PIN_OUT == $past(div_bus.tap[1]))
		else $error("Divide by four output wrong");
	a_bad_floats: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(pfm == 3'h7) ##1 (pfm == 3'h7) |=> !PIN_OE_OUT) else $error("Prohibited mode drives pin");
	a_tmr_watch: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(role == ROLE_TMR) && ($past(role) == ROLE_TMR) && $past(css[0]) |-> PIN_OUT == $past(watch_s2))
		else $error("Watch clock not selected");
	a_tmr_div32: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(role == ROLE_TMR) && ($past(role) == ROLE_TMR) && ($past(css) == 3'h6) |-> PIN_OUT == $past(div_bus.tap[4]))
		else $error("Divide by 32 not selected");
	a_css_readback: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		access_wr && (PADDR_IN == ADDR_CSS) |=> css == $past(PWDATA_IN[6:4])) else $error("Source field not stored");
	a_event_gated: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(role != ROLE_EVT) |-> !EVENT_OUT) else $error("Event input leaks");
	a_event_follow: assert property (@(posedge MCLK_IN) disable iff (!RSTN_IN)
		(pfm == PFM_EVT) && ($past(pfm) == PFM_EVT) |-> (role == ROLE_EVT) && (EVENT_OUT == pin_s2))
		else $error("Event input not routed");
endmodule

// ---- test/scomux_board.sv ----
// Purpose: Board circuit hung on the shared pin
// Assumes: Pull-up on the pin, external driver enabled by the bench
// Notes:   Device drive wins, contention is not modelled
`timescale 1ns/1ps
module scomux_board (
	input  wire logic pin_oe_in,
	input  wire logic pin_drv_in,
	input  wire logic ext_en_in,
	input  wire logic ext_val_in,
	output logic      pin_lvl_out
);
	// Pin released by the device with the external driver disabled reads high, never a stale level
	assign pin_lvl_out = pin_oe_in ? pin_drv_in : (ext_en_in ? ext_val_in : 1'b1);
endmodule

// ---- test/shared_pin_clock_output_mux_test.sv ----
// Purpose: Self-checking bench of the shared pin selector
// Assumes: Zero wait state APB slave, divided clocks counted in edges
// Notes:   64 cycle window is a multiple of every divided period
`timescale 1ns/1ps
module shared_pin_clock_output_mux_test;
	import scomux_pkg::*;
	typedef struct {logic [2:0] m; logic [2:0] s; int n;} scomux_row_t;
	logic              clk, rstn, psel, pen, pwr, tio, tioe, ext_en, ext_val, lvl;
	logic              pready, pslverr, pout, poe, tin, evt, err;
	logic [ADDR_W-1:0] paddr;
	logic [31:0]       pwdata, prdata, rd;
	logic [3:0]        wdiv = 4'h0;
	int                miscompares, check_count, edges, e0;
	scomux_row_t       rows [10] = '{'{3'h4, 3'h0, 64}, '{3'h5, 3'h0, 32}, '{3'h6, 3'h0, 16},
		'{3'h2, 3'h0, 16}, '{3'h3, 3'h2, 8}, '{3'h2, 3'h4, 4}, '{3'h3, 3'h6, 2},
		'{3'h3, 3'h1, 4}, '{3'h2, 3'h7, 4}, '{3'h5, 3'h6, 32}};

	scomux_top i_dut (.MCLK_IN(clk), .RSTN_IN(rstn), .PSEL_IN(psel), .PENABLE_IN(pen),
		.PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .PIN_IN(lvl), .PIN_OUT(pout),
		.PIN_OE_OUT(poe), .WATCH_CLK_IN(wdiv[3]), .TIMER_IO_OUT_IN(tio),
		.TIMER_IO_OE_IN(tioe), .TIMER_IO_IN_OUT(tin), .EVENT_OUT(evt));
	scomux_board i_board (.pin_oe_in(poe), .pin_drv_in(pout), .ext_en_in(ext_en),
		.ext_val_in(ext_val), .pin_lvl_out(lvl));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	always @(posedge clk) wdiv <= wdiv + 4'h1;
	always @(posedge pout) edges++;

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// Answer taken at the completing edge, before that edge updates anything
		@(posedge clk);
		while (pready !== 1'b1) begin
			@(posedge clk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task automatic settle;
		repeat (6) @(posedge clk);
		#1;
	endtask
	task automatic results;
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		#100000;
		miscompares++;
		results;
	end

	initial begin
		{rstn, psel, pen, pwr, tio, tioe, ext_en, ext_val} = 8'h0;
		paddr = '0;
		pwdata = 32'h0;
		repeat (5) @(posedge clk);
		rstn <= 1'b1;
		foreach (rows[i]) begin
			apb(1'b1, ADDR_PFM, {29'h0, rows[i].m});
			apb(1'b1, ADDR_CSS, {25'h0, rows[i].s, 4'h0});
			apb(1'b0, ADDR_PFM, 32'h0);
			chk(rd, {29'h0, rows[i].m});
			apb(1'b0, ADDR_CSS, 32'h0);
			chk(rd, {25'h0, rows[i].s, 4'h0});
			settle;
			e0 = edges;
			repeat (64) @(posedge clk);
			#1;
			chk(edges - e0, rows[i].n);
			chk(poe, 1'b1);
		end
		// Reset in mid-run must fall back to port mode
		@(posedge clk);
		rstn <= 1'b0;
		settle;
		chk(poe, 1'b0);
		@(posedge clk);
		rstn <= 1'b1;
		apb(1'b0, ADDR_PFM, 32'h0);
		chk(rd, 32'h0);
		chk(err, 1'b0);
		apb(1'b0, ADDR_CSS, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, ADDR_PFM + 18'h4, 32'hff);
		chk(err, 1'b1);
		apb(1'b0, ADDR_PFM, 32'h0);
		chk(rd, 32'h0);
		// Port output driven high reads back through the pin
		apb(1'b1, ADDR_PORT, 32'h3);
		settle;
		chk({poe, pout}, 2'h3);
		apb(1'b0, ADDR_PORT, 32'h0);
		chk(rd, 32'h7);
		apb(1'b1, ADDR_PORT, 32'h0);
		@(posedge clk);
		tioe <= 1'b1;
		tio <= 1'b1;
		settle;
		chk({poe, pout}, 2'h3);
		@(posedge clk);
		tioe <= 1'b0;
		ext_en <= 1'b1;
		settle;
		chk({poe, tin, evt}, 3'h0);
		@(posedge clk);
		ext_val <= 1'b1;
		settle;
		chk({tin, evt}, 2'h2);
		apb(1'b1, ADDR_PFM, 32'h1);
		settle;
		chk({poe, tin, evt}, 3'h1);
		@(posedge clk);
		ext_val <= 1'b0;
		settle;
		chk(evt, 1'b0);
		apb(1'b1, ADDR_PFM, 32'h7);
		settle;
		chk(poe, 1'b0);
		results;
	end
endmodule
